/* verilog/axm_master_port.sv */
`timescale 1ns/100ps
`default_nettype none
`include "axm_cfg.svh"

////////////////////////////////////////////////////////////////////////////////
// write data buffer: ready comes from a flop so it has no combinational path from the drain side
module axm_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = `AXM_WFIFO_DEPTH
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [WIDTH-1:0] in_data_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  output logic [WIDTH-1:0] out_data_o,
  output logic out_valid_o,
  input wire logic out_ready_i
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [PW-1:0] wr_ptr_r;
  logic [PW-1:0] rd_ptr_r;
  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;
  logic push;
  logic pop;

  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;
  assign out_valid_o = (cnt_r != '0);
  assign out_data_o = mem_r[rd_ptr_r];

  // occupancy after this cycle's push and pop
  always_comb begin
    cnt_nxt = cnt_r + CW'(push) - CW'(pop);
  end

  // storage needs no reset; the count guards every read
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_r[wr_ptr_r] <= in_data_i;
    end
  end

  // pointers, count and ready
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      cnt_r <= '0;
      in_ready_o <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr_r <= PW'(axm_pkg::axm_wrap_inc(int'(wr_ptr_r), DEPTH));
      end
      if (pop) begin
        rd_ptr_r <= PW'(axm_pkg::axm_wrap_inc(int'(rd_ptr_r), DEPTH));
      end
      cnt_r <= cnt_nxt;
      in_ready_o <= (cnt_nxt != CW'(DEPTH)); // R19
    end
  end
endmodule : axm_fifo

////////////////////////////////////////////////////////////////////////////////
// one master port: master side m_*, fabric side s_*
module axm_master_port #(
  parameter int WR_ACCEPT = `AXM_WR_ACCEPT,
  parameter int RD_ACCEPT = `AXM_RD_ACCEPT,
  parameter int WFIFO_DEPTH = `AXM_WFIFO_DEPTH
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire axm_pkg::axm_ax_t m_aw_i,
  input wire logic m_awvalid_i,
  output logic m_awready_o,
  input wire axm_pkg::axm_w_t m_w_i,
  input wire logic m_wvalid_i,
  output logic m_wready_o,
  output var axm_pkg::axm_b_t m_b_o,
  output logic m_bvalid_o,
  input wire logic m_bready_i,
  input wire axm_pkg::axm_ax_t m_ar_i,
  input wire logic m_arvalid_i,
  output logic m_arready_o,
  output var axm_pkg::axm_r_t m_r_o,
  output logic m_rvalid_o,
  input wire logic m_rready_i,
  output var axm_pkg::axm_ax_t s_aw_o,
  output logic s_awvalid_o,
  input wire logic s_awready_i,
  output var axm_pkg::axm_w_t s_w_o,
  output logic s_wvalid_o,
  input wire logic s_wready_i,
  input wire axm_pkg::axm_b_t s_b_i,
  input wire logic s_bvalid_i,
  output logic s_bready_o,
  output var axm_pkg::axm_ax_t s_ar_o,
  output logic s_arvalid_o,
  input wire logic s_arready_i,
  input wire axm_pkg::axm_r_t s_r_i,
  input wire logic s_rvalid_i,
  output logic s_rready_o
);
  localparam int WQ = (WR_ACCEPT > 1) ? $clog2(WR_ACCEPT) : 1;
  localparam int RQ = (RD_ACCEPT > 1) ? $clog2(RD_ACCEPT) : 1;
  localparam int WC = $clog2(WR_ACCEPT + 1);
  localparam int RC = $clog2(RD_ACCEPT + 1);
  localparam int WW = $bits(axm_pkg::axm_w_t);

  logic rsync1_r;
  logic rst_n;
  logic aw_take, aw_give, ar_take, ar_give;
  logic b_load, b_give, r_load, r_give, r_last;
  logic awvalid_nxt, arvalid_nxt, bvalid_nxt, rvalid_nxt;
  logic [WC-1:0] wr_cnt_r, wr_cnt_nxt;
  logic [RC-1:0] rd_cnt_r, rd_cnt_nxt;
  logic [axm_pkg::id_tag_width_param-1:0] wq_id_r [WR_ACCEPT];
  logic [WQ-1:0] wq_wr_r, wq_rd_r;
  logic [`AXM_LEN_W-1:0] rq_len_r [RD_ACCEPT];
  logic [RQ-1:0] rq_wr_r, rq_rd_r;
  logic [`AXM_LEN_W-1:0] rbeat_r;
  logic [WW-1:0] wf_data;
  logic wf_valid, wf_ready;

  //////////////////////////////////////////////////////////////////////////////
  // reset: asynchronous assertion, release retimed to the clock
  always_ff @(posedge clk_i or negedge reset_n_i) begin // R1
    if (!reset_n_i) begin
      rsync1_r <= 1'b0; // R2
      rst_n <= 1'b0;
    end else begin
      rsync1_r <= 1'b1;
      rst_n <= rsync1_r; // R2
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // handshake terms, all on the rising edge
  assign aw_take = m_awvalid_i && m_awready_o; // R17
  assign aw_give = s_awvalid_o && s_awready_i;
  assign ar_take = m_arvalid_i && m_arready_o; // R18
  assign ar_give = s_arvalid_o && s_arready_i;
  assign b_load = s_bvalid_i && s_bready_o;
  assign b_give = m_bvalid_o && m_bready_i; // R20
  assign r_load = s_rvalid_i && s_rready_o;
  assign r_give = m_rvalid_o && m_rready_i; // R21
  assign r_last = (rbeat_r == rq_len_r[rq_rd_r]); // R16

  // next states of the single-entry stages and the outstanding counts
  always_comb begin
    awvalid_nxt = aw_take ? 1'b1 : (aw_give ? 1'b0 : s_awvalid_o);
    arvalid_nxt = ar_take ? 1'b1 : (ar_give ? 1'b0 : s_arvalid_o);
    bvalid_nxt = b_load ? 1'b1 : (b_give ? 1'b0 : m_bvalid_o);
    rvalid_nxt = r_load ? 1'b1 : (r_give ? 1'b0 : m_rvalid_o);
    wr_cnt_nxt = wr_cnt_r + WC'(aw_take) - WC'(b_load);
    rd_cnt_nxt = rd_cnt_r + RC'(ar_take) - RC'(r_load && r_last);
  end

  //////////////////////////////////////////////////////////////////////////////
  // write address stage; ready drops at the acceptance limit
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      s_aw_o <= '0;
      s_awvalid_o <= 1'b0;
      m_awready_o <= 1'b0; // R25
    end else begin
      if (aw_take) begin
        s_aw_o <= m_aw_i; // R11 R9
        s_aw_o.lock <= `AXM_LOCK_NORMAL; // R24
      end
      s_awvalid_o <= awvalid_nxt;
      m_awready_o <= !awvalid_nxt && (wr_cnt_nxt < WC'(WR_ACCEPT)); // R22
    end
  end

  // issue-order queue of write ids; responses are retagged from its head
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      wq_wr_r <= '0;
      wq_rd_r <= '0;
      wr_cnt_r <= '0;
      for (int i = 0; i < WR_ACCEPT; i++) begin
        wq_id_r[i] <= '0;
      end
    end else begin
      if (aw_take) begin
        wq_id_r[wq_wr_r] <= m_aw_i.id; // R23
        wq_wr_r <= WQ'(axm_pkg::axm_wrap_inc(int'(wq_wr_r), WR_ACCEPT));
      end
      if (b_load) begin
        wq_rd_r <= WQ'(axm_pkg::axm_wrap_inc(int'(wq_rd_r), WR_ACCEPT)); // R23
      end
      wr_cnt_r <= wr_cnt_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // write data through the buffer, then an output register
  axm_fifo #(
    .WIDTH(WW),
    .DEPTH(WFIFO_DEPTH)
  ) u_wfifo (
    .clk_i(clk_i),
    .rst_n_i(rst_n),
    .in_data_i(m_w_i),
    .in_valid_i(m_wvalid_i),
    .in_ready_o(m_wready_o),
    .out_data_o(wf_data),
    .out_valid_o(wf_valid),
    .out_ready_i(wf_ready)
  );

  assign wf_ready = !s_wvalid_o || s_wready_i;

  // full-rate output register; strobes and last travel untouched
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      s_w_o <= '0;
      s_wvalid_o <= 1'b0;
    end else if (wf_ready) begin
      s_wvalid_o <= wf_valid; // R19
      if (wf_valid) begin
        s_w_o <= axm_pkg::axm_w_t'(wf_data); // R6
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // write response stage; taken only while a write is outstanding
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      m_b_o <= '0;
      m_bvalid_o <= 1'b0; // R25
      s_bready_o <= 1'b0;
    end else begin
      if (b_load) begin
        m_b_o.id <= wq_id_r[wq_rd_r]; // R13
        m_b_o.resp <= axm_pkg::axm_map_resp(s_b_i.resp); // R3
      end
      m_bvalid_o <= bvalid_nxt; // R20
      s_bready_o <= !bvalid_nxt && (wr_cnt_nxt != '0);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // read address stage and burst-length queue
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      s_ar_o <= '0;
      s_arvalid_o <= 1'b0;
      m_arready_o <= 1'b0; // R25
    end else begin
      if (ar_take) begin
        s_ar_o <= m_ar_i; // R11 R9
        s_ar_o.lock <= `AXM_LOCK_NORMAL; // R24
      end
      s_arvalid_o <= arvalid_nxt;
      m_arready_o <= !arvalid_nxt && (rd_cnt_nxt < RC'(RD_ACCEPT)); // R18
    end
  end

  // lengths are kept so that read-last does not rely on the fabric
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rq_wr_r <= '0;
      rq_rd_r <= '0;
      rd_cnt_r <= '0;
      rbeat_r <= '0;
      for (int i = 0; i < RD_ACCEPT; i++) begin
        rq_len_r[i] <= '0;
      end
    end else begin
      if (ar_take) begin
        rq_len_r[rq_wr_r] <= m_ar_i.len; // R7
        rq_wr_r <= RQ'(axm_pkg::axm_wrap_inc(int'(rq_wr_r), RD_ACCEPT));
      end
      if (r_load && r_last) begin
        rq_rd_r <= RQ'(axm_pkg::axm_wrap_inc(int'(rq_rd_r), RD_ACCEPT));
        rbeat_r <= '0;
      end else if (r_load) begin
        rbeat_r <= rbeat_r + `AXM_LEN_W'(1);
      end
      rd_cnt_r <= rd_cnt_nxt;
    end
  end

  // read data stage; the id comes from the slave unchanged
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      m_r_o <= '0;
      m_rvalid_o <= 1'b0; // R25
      s_rready_o <= 1'b0;
    end else begin
      if (r_load) begin
        m_r_o.id <= s_r_i.id; // R14
        m_r_o.data <= s_r_i.data;
        m_r_o.resp <= axm_pkg::axm_map_resp(s_r_i.resp); // R4
        m_r_o.last <= r_last; // R16
      end
      m_rvalid_o <= rvalid_nxt; // R21
      s_rready_o <= !rvalid_nxt && (rd_cnt_nxt != '0);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n);

  sequence s_aw_take;
    m_awvalid_i && m_awready_o;
  endsequence

  sequence s_ar_take;
    m_arvalid_i && m_arready_o;
  endsequence

  sequence s_b_stall;
    m_bvalid_o && !m_bready_i;
  endsequence

  sequence s_r_stall;
    m_rvalid_o && !m_rready_i;
  endsequence

  a_bresp_code: assert property (m_bvalid_o |-> m_b_o.resp != `AXM_RESP_DECERR) // R3
    else $error("write response carries decode error");
  a_rresp_code: assert property (m_rvalid_o |-> m_r_o.resp != `AXM_RESP_DECERR) // R4
    else $error("read response carries decode error");
  a_aw_limit_stall: assert property (wr_cnt_r == WC'(WR_ACCEPT) |-> !m_awready_o) // R22
    else $error("write address ready high at acceptance limit");
  a_aw_forward: assert property (s_aw_take |=> s_awvalid_o && s_aw_o.id == $past(m_aw_i.id)) // R17
    else $error("accepted write address not forwarded");
  a_ar_forward: assert property (s_ar_take |=> s_arvalid_o && s_ar_o.addr == $past(m_ar_i.addr)) // R18
    else $error("accepted read address not forwarded");
  a_lock_normal: assert property (s_awvalid_o || s_arvalid_o |->
      s_aw_o.lock == `AXM_LOCK_NORMAL && s_ar_o.lock == `AXM_LOCK_NORMAL) // R24
    else $error("lock type passed to fabric");
  a_b_hold_stable: assert property (s_b_stall |=> m_bvalid_o && $stable(m_b_o)) // R20
    else $error("write response dropped before ready");
  a_r_hold_stable: assert property (s_r_stall |=> m_rvalid_o && $stable(m_r_o)) // R21
    else $error("read data dropped before ready");
  a_bid_order: assert property (b_load |=> m_b_o.id == $past(wq_id_r[wq_rd_r])) // R13
    else $error("write response id not taken from issue queue head");
  a_rlast_count: assert property (r_load && rbeat_r == rq_len_r[rq_rd_r] |=> m_r_o.last) // R16
    else $error("read last missing on final beat");
  a_rid_pass: assert property (r_load |=> m_r_o.id == $past(s_r_i.id)) // R14
    else $error("read id altered");
  a_wq_count: assert property (aw_take && !b_load |=> wr_cnt_r == $past(wr_cnt_r) + WC'(1)) // R23
    else $error("outstanding write count not advanced");

endmodule : axm_master_port

`default_nettype wire

/* pkg/axm_cfg.svh */
// Function
// (R1) every register samples and updates on the rising edge of the one clock.
// (R2) reset is active low, asserts asynchronously, releases synchronously; clears all registers. The write buffer storage (mem_r) has no reset.
// (R3) write response codes: 00 okay, 01 exclusive okay, 10 slave error; never 11.
// (R4) read response codes: 00 okay, 01 exclusive okay, 10 slave error; never 11.
// (R5) master drives eight strobes, strobe n qualifies data byte n.
// (R6) write and read data buses are 64 bits wide.
// (R7) master supplies a 4-bit burst length giving the exact number of beats. The port counts len + 1 beats per burst.
// (R8) master supplies a 3-bit burst size giving bytes per beat.
// (R9) master supplies 2-bit burst type; with size it sets each beat address.
// (R10) master supplies a 2-bit lock type on each address channel.
// (R11) master presents only the burst start address; later addresses are derived.
// (R12) master tags each write beat with the id of its write address.
// (R13) each write response carries the id of its write address.
// (R14) read data carries the slave-produced id matching its read address.
// (R15) master raises write-last on the final write beat only.
// (R16) read-last is raised on the final beat of every read burst.
// (R17) write address moves when master valid and port ready are both high.
// (R18) read address moves when master valid and port ready are both high.
// (R19) write data moves when master valid and port ready are both high.
// (R20) write response stands valid until the master shows ready.
// (R21) read data stands valid until the master shows ready.
// (R22) write address ready is held low while outstanding writes reach the limit.
// (R23) write responses return in the order the write addresses were issued.
// (R24) locked transfers are not supported; lock type never changes behaviour.
// (R25) all ready and valid outputs toward the master are low during reset.
`ifndef AXM_CFG_SVH
`define AXM_CFG_SVH

`define AXM_ID_W 4
`define AXM_ADDR_W 32
`define AXM_DATA_W 64
`define AXM_STRB_W 8
`define AXM_LEN_W 4
`define AXM_SIZE_W 3
`define AXM_BURST_W 2
`define AXM_LOCK_W 2
`define AXM_RESP_W 2

`define AXM_RESP_OKAY 2'h0
`define AXM_RESP_EXOKAY 2'h1
`define AXM_RESP_SLVERR 2'h2
`define AXM_RESP_DECERR 2'h3
`define AXM_LOCK_NORMAL 2'h0

`define AXM_WR_ACCEPT 4
`define AXM_RD_ACCEPT 4
`define AXM_WFIFO_DEPTH 4

`endif

/* pkg/axm_pkg.sv */
`include "axm_cfg.svh"

package axm_pkg;

  localparam int id_tag_width_param = `AXM_ID_W;
  localparam int address_bus_width_param = `AXM_ADDR_W;
  localparam int data_bus_width_param = `AXM_DATA_W;

  // address and control of one burst, shared by both address channels
  typedef struct packed {
    logic [id_tag_width_param-1:0] id;
    logic [address_bus_width_param-1:0] addr;
    logic [`AXM_LEN_W-1:0] len;
    logic [`AXM_SIZE_W-1:0] size;
    logic [`AXM_BURST_W-1:0] burst;
    logic [`AXM_LOCK_W-1:0] lock;
  } axm_ax_t;

  typedef struct packed {
    logic [id_tag_width_param-1:0] id;
    logic [data_bus_width_param-1:0] data;
    logic [`AXM_STRB_W-1:0] strb;
    logic last;
  } axm_w_t;

  typedef struct packed {
    logic [id_tag_width_param-1:0] id;
    logic [`AXM_RESP_W-1:0] resp;
  } axm_b_t;

  typedef struct packed {
    logic [id_tag_width_param-1:0] id;
    logic [data_bus_width_param-1:0] data;
    logic [`AXM_RESP_W-1:0] resp;
    logic last;
  } axm_r_t;

  // circular pointer step for queues of any depth
  function automatic int axm_wrap_inc(input int ptr, input int depth);
    return (ptr == depth - 1) ? 0 : ptr + 1;
  endfunction : axm_wrap_inc

  // the port has no decode-error answer; a stray one is reported as slave error
  function automatic logic [`AXM_RESP_W-1:0] axm_map_resp(input logic [`AXM_RESP_W-1:0] r);
    return (r == `AXM_RESP_DECERR) ? `AXM_RESP_SLVERR : r;
  endfunction : axm_map_resp

endpackage : axm_pkg

/* tb/axm_fabric_model.sv */
`timescale 1ns/100ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// fabric stand-in: takes addresses at once, answers writes in issue order
module axm_fabric_model (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic w_stall_i,
  input wire logic b_stall_i,
  input wire logic [1:0] resp_i,
  output logic awready_o,
  input wire axm_pkg::axm_w_t w_i,
  input wire logic wvalid_i,
  output logic wready_o,
  output var axm_pkg::axm_b_t b_o,
  output logic bvalid_o,
  input wire logic bready_i,
  input wire axm_pkg::axm_ax_t ar_i,
  input wire logic arvalid_i,
  output logic arready_o,
  output var axm_pkg::axm_r_t r_o,
  output logic rvalid_o,
  input wire logic rready_i
);
  axm_pkg::axm_ax_t rq[$];
  int bcnt;
  int beat;

  // released lines flip so a stale value never looks like a fresh one
  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      {awready_o, arready_o, wready_o, bvalid_o, rvalid_o} <= 5'h0;
      b_o <= '0;
      r_o <= '0;
      bcnt = 0;
      beat = 0;
      rq.delete();
    end else begin
      awready_o <= 1'b1;
      arready_o <= 1'b1;
      wready_o <= !w_stall_i;
      if (wvalid_i && wready_o && w_i.last) bcnt++;
      if (arvalid_i && arready_o) rq.push_back(ar_i);
      if (bvalid_o && bready_i) begin
        bvalid_o <= 1'b0;
        b_o <= ~b_o;
      end else if (!bvalid_o && bcnt > 0 && !b_stall_i) begin
        bvalid_o <= 1'b1;
        b_o.id <= 4'hF; // fabric id is not the master's
        b_o.resp <= resp_i;
        bcnt--;
      end
      if (rvalid_o && rready_i) begin
        rvalid_o <= 1'b0;
        r_o <= ~r_o;
        if (beat == int'(rq[0].len)) begin
          beat = 0;
          void'(rq.pop_front());
        end else beat++;
      end else if (!rvalid_o && rq.size() > 0) begin
        rvalid_o <= 1'b1;
        r_o.id <= rq[0].id;
        r_o.data <= 64'h5A5A_0000_0000_0000 | 64'(beat);
        r_o.resp <= resp_i;
        r_o.last <= (beat == int'(rq[0].len));
      end
    end
  end
endmodule : axm_fabric_model

`default_nettype wire

/* tb/tb.sv */
`timescale 1ns/100ps
`default_nettype none

module tb;
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  axm_pkg::axm_ax_t m_aw = '0;
  axm_pkg::axm_ax_t m_ar = '0;
  axm_pkg::axm_w_t m_w = '0;
  logic m_awvalid = 1'b0;
  logic m_wvalid = 1'b0;
  logic m_bready = 1'b0;
  logic m_arvalid = 1'b0;
  logic m_rready = 1'b0;
  logic w_stall = 1'b0;
  logic b_stall = 1'b0;
  logic [1:0] resp_sel = 2'h0;
  logic m_awready, m_wready, m_bvalid, m_arready, m_rvalid;
  axm_pkg::axm_b_t m_b, s_b;
  axm_pkg::axm_r_t m_r, s_r;
  axm_pkg::axm_ax_t s_aw, s_ar, s_aw_seen;
  axm_pkg::axm_w_t s_w, s_w_seen;
  logic s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
  logic s_arvalid, s_arready, s_rvalid, s_rready;
  int mismatches = 0;
  int num_checks = 0;
  int cycles = 0;
  int aw_cnt = 0;
  int w_cnt = 0;
  int base;

  always #10 clk_i = ~clk_i;

  axm_master_port i_dut (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .m_aw_i(m_aw), .m_awvalid_i(m_awvalid), .m_awready_o(m_awready),
    .m_w_i(m_w), .m_wvalid_i(m_wvalid), .m_wready_o(m_wready),
    .m_b_o(m_b), .m_bvalid_o(m_bvalid), .m_bready_i(m_bready),
    .m_ar_i(m_ar), .m_arvalid_i(m_arvalid), .m_arready_o(m_arready),
    .m_r_o(m_r), .m_rvalid_o(m_rvalid), .m_rready_i(m_rready),
    .s_aw_o(s_aw), .s_awvalid_o(s_awvalid), .s_awready_i(s_awready),
    .s_w_o(s_w), .s_wvalid_o(s_wvalid), .s_wready_i(s_wready),
    .s_b_i(s_b), .s_bvalid_i(s_bvalid), .s_bready_o(s_bready),
    .s_ar_o(s_ar), .s_arvalid_o(s_arvalid), .s_arready_i(s_arready),
    .s_r_i(s_r), .s_rvalid_i(s_rvalid), .s_rready_o(s_rready));

  axm_fabric_model i_fabric (.clk_i(clk_i), .reset_n_i(reset_n_i), .w_stall_i(w_stall),
    .b_stall_i(b_stall), .resp_i(resp_sel), .awready_o(s_awready), .w_i(s_w),
    .wvalid_i(s_wvalid), .wready_o(s_wready), .b_o(s_b), .bvalid_o(s_bvalid),
    .bready_i(s_bready), .ar_i(s_ar), .arvalid_i(s_arvalid), .arready_o(s_arready),
    .r_o(s_r), .rvalid_o(s_rvalid), .rready_i(s_rready));

  ////////////////////////////////////////////////////////////////////////////////
  // handshake monitor and hang guard
  always @(posedge clk_i) begin
    cycles++;
    if (m_awvalid && m_awready) aw_cnt++;
    if (m_wvalid && m_wready) w_cnt++;
    if (s_awvalid && s_awready) s_aw_seen <= s_aw;
    if (s_wvalid && s_wready) s_w_seen <= s_w;
    if (cycles == 5000) begin
      mismatches++;
      $display("CHECK FAILED at %0t: run timed out", $time);
      finish_test();
    end
  end

  // wide enough for a whole write beat (77 bits)
  task automatic check(input logic [79:0] seen, input logic [79:0] exp, input string what);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  // bounded wait for a ready or valid sampled high at an edge
  task automatic wait_hi(ref logic sig);
    int n;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (sig !== 1'b1 && n < 200);
    check(n < 200, 1'b1, "handshake wait");
  endtask : wait_hi

  // start address only, beat count minus one, size, type and lock per burst
  function automatic axm_pkg::axm_ax_t mk_ax(input logic [3:0] id, input logic [3:0] len);
    return '{id: id, addr: 32'h1000_0040, len: len, size: 3'h3, burst: 2'h1, lock: 2'h1};
  endfunction : mk_ax

  task automatic send_aw(input axm_pkg::axm_ax_t a);
    m_aw <= a;
    m_awvalid <= 1'b1;
    wait_hi(m_awready);
    m_awvalid <= 1'b0;
    @(posedge clk_i);
  endtask : send_aw

  task automatic send_ar(input axm_pkg::axm_ax_t a);
    m_ar <= a;
    m_arvalid <= 1'b1;
    wait_hi(m_arready);
    m_arvalid <= 1'b0;
    @(posedge clk_i);
  endtask : send_ar

  // beats carry the address id, strobes narrowing by one lane each beat, last on the final beat only
  task automatic write_burst(input logic [3:0] id, input int len);
    for (int i = 0; i <= len; i++) begin
      m_w <= '{id: id, data: 64'hC0DE_0000_0000_0000 | 64'(i), strb: 8'hFF >> i, last: i == len};
      m_wvalid <= 1'b1;
      wait_hi(m_wready);
    end
    m_wvalid <= 1'b0;
    @(posedge clk_i);
  endtask : write_burst

  task automatic get_b(input logic [3:0] id, input logic [1:0] resp);
    m_bready <= 1'b1;
    wait_hi(m_bvalid);
    check(m_b, {id, resp}, "write response");
    m_bready <= 1'b0;
    @(posedge clk_i);
  endtask : get_b

  task automatic get_r(input logic [3:0] id, input int beat, input logic last, input logic [1:0] resp);
    m_rready <= 1'b1;
    wait_hi(m_rvalid);
    check(m_r, {id, 64'h5A5A_0000_0000_0000 | 64'(beat), resp, last}, "read beat");
    m_rready <= 1'b0;
    @(posedge clk_i);
  endtask : get_r

  task automatic do_reset();
    @(posedge clk_i);
    reset_n_i <= 1'b0;
    #2;
    check({m_awready, m_wready, m_arready, m_bvalid, m_rvalid}, 5'h0, "in reset");
    repeat (2) @(posedge clk_i);
    reset_n_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    #1 check(m_awready, 1'b0, "ready early");
    @(posedge clk_i);
    #1 check({m_awready, m_wready, m_arready}, 3'h7, "ready after release");
    @(posedge clk_i);
    $display("test reset done");
  endtask : do_reset

  task automatic t_write();
    axm_pkg::axm_ax_t a;
    a = mk_ax(4'h5, 4'h3);
    send_aw(a);
    write_burst(4'h5, 3);
    repeat (8) @(posedge clk_i); // ready held low so the response has to stand
    check(m_bvalid, 1'b1, "response stands");
    get_b(4'h5, 2'h0);
    a.lock = 2'h0;
    check(s_aw_seen, a, "forwarded address");
    check(s_w_seen, {4'h5, 64'hC0DE_0000_0000_0003, 8'h1F, 1'b1}, "last beat");
    $display("test write done");
  endtask : t_write

  // every response code on both channels; the unsupported code comes back as slave error
  task automatic t_resp();
    for (int k = 0; k < 4; k++) begin
      resp_sel <= 2'(k);
      send_aw(mk_ax(4'(k + 8), 4'h0));
      write_burst(4'(k + 8), 0);
      get_b(4'(k + 8), (k == 3) ? 2'h2 : 2'(k));
      send_ar(mk_ax(4'(k), 4'h0));
      get_r(4'(k), 0, 1'b1, (k == 3) ? 2'h2 : 2'(k));
    end
    resp_sel <= 2'h0;
    $display("test responses done");
  endtask : t_resp

  // fill the acceptance limit, see the fifth address stall, then drain in order
  task automatic t_order();
    b_stall <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      send_aw(mk_ax(4'(i * 3 + 1), 4'h0));
      write_burst(4'(i * 3 + 1), 0);
    end
    base = aw_cnt;
    fork
      send_aw(mk_ax(4'hD, 4'h0));
      begin
        repeat (10) @(posedge clk_i);
        check(aw_cnt, base, "address over limit");
        b_stall <= 1'b0;
        for (int i = 0; i < 4; i++) get_b(4'(i * 3 + 1), 2'h0);
      end
    join
    write_burst(4'hD, 0);
    get_b(4'hD, 2'h0);
    $display("test limit and order done");
  endtask : t_order

  task automatic t_read();
    send_ar(mk_ax(4'h9, 4'h2));
    send_ar(mk_ax(4'h4, 4'h0));
    for (int i = 0; i < 3; i++) get_r(4'h9, i, i == 2, 2'h0);
    get_r(4'h4, 0, 1'b1, 2'h0);
    $display("test read done");
  endtask : t_read

  // fabric stalls write data: the buffer must take at least four beats then refuse
  task automatic t_fifo();
    w_stall <= 1'b1;
    send_aw(mk_ax(4'h2, 4'h7));
    base = w_cnt;
    fork
      write_burst(4'h2, 7);
      begin
        repeat (20) @(posedge clk_i);
        check(m_wready, 1'b0, "buffer full");
        check(w_cnt - base >= 4, 1'b1, "buffer depth");
        w_stall <= 1'b0;
      end
    join
    get_b(4'h2, 2'h0);
    check(s_w_seen, {4'h2, 64'hC0DE_0000_0000_0007, 8'h01, 1'b1}, "drained last");
    $display("test buffer done");
  endtask : t_fifo

  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : finish_test

  initial begin
    do_reset();
    t_write();
    t_resp();
    t_order();
    do_reset();
    t_read();
    t_fifo();
    finish_test();
  end
endmodule : tb

`default_nettype wire
